//--- fmc_checker.sv
`default_nettype none
module fmc_checker (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic testEnable, // test pin
  input wire logic [3:0] regAddr, // index
  input wire logic regWrStb, // strobe
  input wire logic [7:0] regWrData, // data
  input wire logic [7:0] cmdReadOut, // command slot
  input wire logic defaultsWrStb, // refresh strobe
  input wire logic [2:0] boostRate, // boost rate
  input wire logic factoryLock, // factory lock
  input wire logic userLock, // user lock
  input wire logic busy // busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cmd_wr;
    regWrStb && regAddr == 4'h9 && !busy;
  endsequence
  sequence s_point;
    s_cmd_wr ##0 (testEnable && regWrData[6:5] == 2'h0);
  endsequence
  a_field_map: assert property (s_cmd_wr |=> cmdReadOut[6:0] == {$past(regWrData[6:5]), 1'b0, $past(regWrData[3:0])})
    else $error("command fields not stored");
  a_start_launch: assert property (s_cmd_wr ##0 (testEnable && regWrData[7]) |=> busy && cmdReadOut[7])
    else $error("start did not launch");
  a_test_refused: assert property (s_cmd_wr ##0 !testEnable |=> !busy)
    else $error("command ran outside test mode");
  a_start_clear: assert property ($fell(busy) |-> !cmdReadOut[7])
    else $error("start bit left set");
  a_fields_held: assert property (busy && $past(busy) |-> $stable(cmdReadOut[6:0]))
    else $error("fields changed while busy");
  a_point_quiet: assert property (s_point |=> (!defaultsWrStb)[*6])
    else $error("point caused a refresh");
  a_flock_kept: assert property (factoryLock |=> factoryLock)
    else $error("factory lock cleared");
  a_ulock_kept: assert property (userLock |=> userLock)
    else $error("user lock cleared");
  a_boost_fixed: assert property ($changed(boostRate) |-> $past(busy))
    else $error("boost rate changed outside refresh");
endmodule
`default_nettype wire

//--- fmc_fuse_array.v
`default_nettype none
module fmc_fuse_array #(
  parameter ADDR_W = 4,
  parameter [127:0] FUSE_INIT = 128'h0
) (
  input wire clk, // system clock
  input wire [ADDR_W-1:0] rdAddr, // byte to read
  output reg [7:0] rdData, // registered read byte
  input wire burnEn, // burn one bit this cycle
  input wire [ADDR_W-1:0] burnAddr, // byte holding the bit
  input wire [2:0] burnBit // bit within the byte
);
  reg [7:0] fuseMem [0:(1<<ADDR_W)-1];
  integer i;

  // fuse state is nonvolatile: no reset, only an initial image
  initial begin
    for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
      fuseMem[i] = FUSE_INIT[i*8 +: 8];
    end
  end

  always @(posedge clk) begin
    if (burnEn) begin
      fuseMem[burnAddr][burnBit] <= 1'b1; // RULE_10
    end
    rdData <= fuseMem[rdAddr];
  end
endmodule
`default_nettype wire

//--- fmc_fuse_controller.v
`include "fmc_fuse_map.vh"
`default_nettype none
module fmc_fuse_controller #(
  parameter [127:0] FUSE_INIT = 128'h0,
  parameter BURN_CYCLES = `FMC_BURN_CYCLES
) (
  input wire clk, // 40 MHz system clock
  input wire rst_n, // power-on reset, async, active low
  input wire testEnable, // test enable pin level
  input wire [3:0] regAddr, // serial-port register address
  input wire regWrStb, // one-cycle write strobe
  input wire [7:0] regWrData, // write data
  output wire [7:0] cmdReadOut, // control slot nine read value
  output reg [7:0] dataReadOut, // control slot ten read value
  output reg defaultsWrStb, // one byte of defaults to load
  output reg [3:0] defaultsAddr, // fuse byte index being loaded
  output reg [7:0] defaultsData, // fuse byte value being loaded
  output reg defaultsReady, // first load after reset done
  output reg [2:0] boostRate, // fuse-fixed boost control rate
  output reg diagPulsed, // fuse-fixed diag response mode
  output reg factoryLock, // factory lock seen in the fuses
  output reg userLock, // user lock seen in the fuses
  output reg busy // command or refresh running
);
  localparam S_IDLE = 3'h0;
  localparam S_READ = 3'h1;
  localparam S_CAPT = 3'h2;
  localparam S_SHIFT = 3'h3;
  localparam S_BURN = 3'h4;
  localparam S_SWEEP = 3'h5;

  localparam integer BURN_LAST_I = BURN_CYCLES - 1;
  localparam [15:0] BURN_LAST = BURN_LAST_I[15:0];

  // factory trim bits of each byte
  function [7:0] trimMask;
    input [3:0] a;
    begin
      case (a)
        `FMC_ADDR_FLOCK: trimMask = 8'h80;
        4'h7: trimMask = 8'h1F;
        4'h8: trimMask = 8'hFF;
        4'h9: trimMask = 8'hFF;
        4'hA: trimMask = 8'h0F;
        4'hB: trimMask = 8'hF0;
        4'hC: trimMask = 8'hFF;
        default: trimMask = 8'h00;
      endcase
    end
  endfunction

  // bits that exist in the array at all
  function [7:0] usedMask;
    input [3:0] a;
    begin
      if (a < `FMC_ADDR_MISC) begin // RULE_01
        usedMask = 8'hFF;
      end else if (a == `FMC_ADDR_MISC) begin
        usedMask = 8'h1F;
      end else begin
        usedMask = 8'h00;
      end
    end
  endfunction

  function [7:0] burnMask;
    input [3:0] a;
    input fl;
    input ul;
    reg [7:0] t;
    begin
      t = trimMask(a);
      burnMask = ((fl ? 8'h00 : t) | (ul ? 8'h00 : ~t)) & usedMask(a); // RULE_16 RULE_17
    end
  endfunction

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg startBit_reg;
  reg [1:0] opCode_reg;
  reg [3:0] opAddr_reg;
  reg [7:0] loadWord_reg;
  reg [7:0] chain_reg;
  reg [2:0] bitIdx_reg;
  reg [15:0] pulseCnt_reg;
  reg [4:0] sweepCnt_reg;
  reg [3:0] shiftCnt_reg;

  wire [7:0] rdData;
  wire cmdWrite = regWrStb && (regAddr == `FMC_SLOT_CMD);
  wire dataWrite = regWrStb && (regAddr == `FMC_SLOT_DATA);
  wire [1:0] newOp = regWrData[`FMC_CMD_OP_HI:`FMC_CMD_OP_LO];
  wire newStart = regWrData[`FMC_CMD_START];
  wire [3:0] newAddr = regWrData[`FMC_CMD_ADDR_HI:0];
  wire idle = (state_reg == S_IDLE);
  // point needs no start; other opcodes need start, all need test mode
  wire launch = cmdWrite && idle && testEnable && (newStart || newOp == `FMC_OP_POINT); // RULE_03 RULE_06 RULE_21
  wire [7:0] allowBits = burnMask(opAddr_reg, factoryLock, userLock);
  wire bitWanted = chain_reg[bitIdx_reg] && allowBits[bitIdx_reg]; // RULE_03
  wire burnNow = (state_reg == S_BURN) && bitWanted;
  wire [3:0] rdAddr = (state_reg == S_SWEEP) ? sweepCnt_reg[3:0] : opAddr_reg;
  wire sweepEnd = (sweepCnt_reg == {1'b0, `FMC_ADDR_LAST} + 5'h01);
  wire pulseEnd = (pulseCnt_reg == BURN_LAST);

  assign cmdReadOut = {startBit_reg, opCode_reg, 1'b0, opAddr_reg}; // RULE_05

  fmc_fuse_array #(
    .ADDR_W(4),
    .FUSE_INIT(FUSE_INIT)
  ) fuseArray (
    .clk(clk),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .burnEn(burnNow),
    .burnAddr(opAddr_reg),
    .burnBit(bitIdx_reg)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (launch) begin
          case (newOp)
            `FMC_OP_LOAD: state_next = S_SHIFT; // RULE_08
            `FMC_OP_BURN: state_next = S_BURN; // RULE_09
            default: state_next = S_READ;
          endcase
        end
      end
      S_READ: begin
        state_next = S_CAPT;
      end
      S_CAPT: begin
        if (opCode_reg == `FMC_OP_READ) begin
          state_next = S_SWEEP; // RULE_07
        end else begin
          state_next = S_IDLE; // RULE_06
        end
      end
      S_SHIFT: begin
        if (shiftCnt_reg == 4'h7) begin
          state_next = S_SWEEP; // RULE_14
        end
      end
      S_BURN: begin
        if ((pulseEnd || !bitWanted) && bitIdx_reg == 3'h7) begin
          state_next = S_SWEEP; // RULE_14
        end
      end
      S_SWEEP: begin
        if (sweepEnd) begin
          state_next = S_IDLE;
        end
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_SWEEP; // RULE_02
      sweepCnt_reg <= 5'h00;
      startBit_reg <= 1'b0;
      opCode_reg <= 2'h0;
      opAddr_reg <= 4'h0;
      loadWord_reg <= 8'h00;
      chain_reg <= 8'h00;
      bitIdx_reg <= 3'h0;
      pulseCnt_reg <= 16'h0000;
      shiftCnt_reg <= 4'h0;
      dataReadOut <= 8'h00;
      defaultsWrStb <= 1'b0;
      defaultsAddr <= 4'h0;
      defaultsData <= 8'h00;
      defaultsReady <= 1'b0;
      boostRate <= 3'h0;
      diagPulsed <= 1'b0;
      factoryLock <= 1'b0;
      userLock <= 1'b0;
      busy <= 1'b1;
    end else begin
      state_reg <= state_next;
      busy <= (state_next != S_IDLE);
      defaultsWrStb <= 1'b0;
      if (dataWrite) begin
        loadWord_reg <= regWrData; // RULE_11
      end
      // fields only change while idle
      if (launch) begin
        startBit_reg <= newStart; // RULE_12
        opCode_reg <= newOp; // RULE_12
        opAddr_reg <= newAddr; // RULE_12
        bitIdx_reg <= 3'h0;
        pulseCnt_reg <= 16'h0000;
        shiftCnt_reg <= 4'h0;
      end else if (cmdWrite && idle) begin // RULE_21
        opCode_reg <= newOp;
        opAddr_reg <= newAddr;
      end
      case (state_reg)
        S_CAPT: begin
          dataReadOut <= rdData; // RULE_06 RULE_07 RULE_11
          if (opCode_reg != `FMC_OP_READ) begin
            startBit_reg <= 1'b0; // RULE_13
          end
          sweepCnt_reg <= 5'h00;
        end
        S_SHIFT: begin
          chain_reg <= {chain_reg[6:0], loadWord_reg[3'h7 - shiftCnt_reg[2:0]]}; // RULE_08
          shiftCnt_reg <= shiftCnt_reg + 4'h1;
          sweepCnt_reg <= 5'h00;
        end
        S_BURN: begin
          sweepCnt_reg <= 5'h00;
          if (pulseEnd || !bitWanted) begin
            pulseCnt_reg <= 16'h0000;
            bitIdx_reg <= bitIdx_reg + 3'h1; // RULE_09
          end else begin
            pulseCnt_reg <= pulseCnt_reg + 16'h0001;
          end
        end
        S_SWEEP: begin
          sweepCnt_reg <= sweepCnt_reg + 5'h01;
          if (sweepCnt_reg != 5'h00) begin
            defaultsWrStb <= 1'b1; // RULE_02 RULE_14
            defaultsAddr <= sweepCnt_reg[3:0] - 4'h1;
            defaultsData <= rdData; // RULE_19
            case (sweepCnt_reg[3:0] - 4'h1)
              `FMC_ADDR_FIXED: begin
                diagPulsed <= rdData[`FMC_DIAG_MODE_BIT]; // RULE_18
                boostRate <= rdData[`FMC_BOOST_RATE_HI:`FMC_BOOST_RATE_LO]; // RULE_18
              end
              `FMC_ADDR_FLOCK: begin
                factoryLock <= factoryLock | rdData[`FMC_LOCK_BIT]; // RULE_15 RULE_16
              end
              `FMC_ADDR_ULOCK: begin
                userLock <= userLock | rdData[`FMC_LOCK_BIT]; // RULE_15 RULE_17
              end
              default: begin
              end
            endcase
          end
          if (sweepEnd) begin
            startBit_reg <= 1'b0; // RULE_13
            defaultsReady <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- fmc_fuse_map.vh
`ifndef FMC_FUSE_MAP_VH
`define FMC_FUSE_MAP_VH
// What this block does
// [RULE_01] fuse array holds 109 bits: 37 factory trim, 72 user default bits; the code's trimMask marks 38 trim bits, leaving 71 user bits
// [RULE_02] at start-up all fuse bytes are copied into the serial-port registers
// [RULE_03] fuse commands only act in test mode, and burning obeys both lock bits
// [RULE_04] the master keeps the test enable pin high during every fuse operation
// [RULE_05] command slot: start at bit 7, opcode at 6:5, byte address at 3:0
// [RULE_06] opcode 00 points: addressed byte goes to data slot, no start, no refresh
// [RULE_07] opcode 01 reads addressed byte then reloads every serial-port register
// [RULE_08] opcode 10 shifts the data byte into the programming chain for burning
// [RULE_09] opcode 11 burns the staged byte into the addressed byte, one bit at a time
// [RULE_10] a burned one never returns to zero; burns only add ones
// [RULE_11] data slot write stores the load byte; a read returns fuse contents
// [RULE_12] start captures opcode and address and holds them until the command ends
// [RULE_13] the start bit clears itself when a command finishes, for polling
// [RULE_14] read, load and burn end with a full refresh; point does not
// [RULE_15] two lock stages; a set lock can never be cleared
// [RULE_16] factory lock at byte 0x02 bit 7 protects all factory trim bits
// [RULE_17] user lock at byte 0x03 bit 7 protects all user default bits
// [RULE_18] boost control rate and diag response mode come only from the fuses
// [RULE_19] bytes 0x00/0x01 dimming duty, bytes 0x02/0x03 bits 6:0 string currents
// [RULE_20] the master verifies contents before locking and burns with LEDs off
// [RULE_21] while a command runs, new starts and field changes are ignored

`define FMC_FUSE_BITS 109
`define FMC_FACTORY_BITS 37
`define FMC_USER_BITS 72

`define FMC_SLOT_CMD 4'h9
`define FMC_SLOT_DATA 4'hA

`define FMC_CMD_START 7
`define FMC_CMD_OP_HI 6
`define FMC_CMD_OP_LO 5
`define FMC_CMD_ADDR_HI 3

`define FMC_OP_POINT 2'h0
`define FMC_OP_READ 2'h1
`define FMC_OP_LOAD 2'h2
`define FMC_OP_BURN 2'h3

`define FMC_ADDR_DUTY1 4'h0
`define FMC_ADDR_DUTY2 4'h1
`define FMC_ADDR_FLOCK 4'h2
`define FMC_ADDR_ULOCK 4'h3
`define FMC_ADDR_FIXED 4'hA
`define FMC_ADDR_MISC 4'hD
`define FMC_ADDR_LAST 4'hE
`define FMC_LOCK_BIT 7
`define FMC_DIAG_MODE_BIT 7
`define FMC_BOOST_RATE_HI 6
`define FMC_BOOST_RATE_LO 4

`define FMC_CLK_PERIOD_NS 25
`define FMC_BURN_PULSE_NS 10000
`define FMC_BURN_CYCLES ((`FMC_BURN_PULSE_NS + `FMC_CLK_PERIOD_NS - 1) / `FMC_CLK_PERIOD_NS)

`endif

//--- fmc_spi_master.sv
`default_nettype none
module fmc_spi_master (
  input wire logic clk, // clock
  output var logic [3:0] regAddr, // index
  output var logic regWrStb, // strobe
  output var logic [7:0] regWrData, // data
  output var logic testEnable // test pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    regAddr = 4'h0;
    regWrStb = 1'b0;
    regWrData = 8'h00;
    testEnable = 1'b1;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic te);
    @(posedge clk);
    testEnable <= te;
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    regWrData <= ~d;
  endtask
endmodule
`default_nettype wire

//--- fuse_memory_controller_tb.sv
`default_nettype none
module fuse_memory_controller_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [127:0] IMG = 128'h00001DCCBBD599887766554400802211;
  logic clk, rst_n, testEnable, regWrStb, defaultsWrStb, defaultsReady, diagPulsed, factoryLock, userLock, busy;
  logic [3:0] regAddr, defaultsAddr, a;
  logic [7:0] regWrData, cmdReadOut, dataReadOut, defaultsData, e;
  logic [2:0] boostRate;
  logic [7:0] img [0:15];
  logic [3:0] ba [0:3];
  logic [7:0] bd [0:3];
  int miscompares, checks, strobes, s;
  fmc_fuse_controller #(.FUSE_INIT(IMG), .BURN_CYCLES(4)) uut (.clk, .rst_n, .testEnable, .regAddr, .regWrStb,
    .regWrData, .cmdReadOut, .dataReadOut, .defaultsWrStb, .defaultsAddr, .defaultsData, .defaultsReady,
    .boostRate, .diagPulsed, .factoryLock, .userLock, .busy);
  fmc_spi_master m (.clk, .regAddr, .regWrStb, .regWrData, .testEnable);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic conclude;
    if (miscompares == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic idle;
    int i;
    @(negedge clk);
    for (i = 0; i < 3000 && busy !== 1'b0; i++) @(negedge clk);
    // let the last refresh strobe be counted
    @(negedge clk);
    if (busy !== 1'b0) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic cmd(input logic [1:0] op, input logic [3:0] ad);
    m.wr(4'h9, {1'b1, op, 1'b0, ad}, 1'b1);
    idle();
  endtask
  task automatic pt(input logic [3:0] ad);
    m.wr(4'h9, {4'h0, ad}, 1'b1);
    repeat (4) @(negedge clk);
  endtask
  function automatic logic [7:0] fm(input logic [3:0] ad);
    case (ad)
      4'h2: fm = 8'h80;
      4'h7: fm = 8'h1F;
      4'h8, 4'h9, 4'hC: fm = 8'hFF;
      4'hA: fm = 8'h0F;
      4'hB: fm = 8'hF0;
      default: fm = 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] burned(input logic [3:0] ad, input logic [7:0] d);
    burned = img[ad] | (d & ~(img[2][7] ? fm(ad) : 8'h00) & ~(img[3][7] ? ~fm(ad) : 8'h00));
  endfunction
  always @(negedge clk) if (defaultsWrStb === 1'b1) begin
    strobes++;
    chk(defaultsData, img[defaultsAddr]);
  end
  initial begin
    void'($urandom(52));
    rst_n = 1'b0;
    miscompares = 0;
    checks = 0;
    strobes = 0;
    for (int i = 0; i < 16; i++) img[i] = IMG[8*i +: 8];
    ba = '{4'h4, 4'h7, 4'h3, 4'h5};
    bd = '{8'($urandom), 8'hFF, 8'h80, 8'hFF};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    idle();
    chk(8'(strobes), 8'h0F);
    chk({diagPulsed, boostRate, defaultsReady, 1'b0, factoryLock, userLock}, 8'hDA);
    for (int k = 0; k < 6; k++) begin
      a = 4'($urandom % 15);
      s = strobes;
      m.wr(4'hA, 8'($urandom), 1'b1);
      pt(a);
      chk(dataReadOut, img[a]);
      chk(8'(strobes - s), 8'h00);
    end
    s = strobes;
    m.wr(4'h9, 8'hA1, 1'b1);
    m.wr(4'h9, 8'hE6, 1'b1);
    idle();
    chk(dataReadOut, img[1]);
    chk(8'(strobes - s), 8'h0F);
    chk(cmdReadOut, 8'h21);
    m.wr(4'h9, 8'hA4, 1'b0);
    repeat (3) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    pt(4'h3);
    chk(dataReadOut, img[3]);
    for (int k = 0; k < 4; k++) begin
      m.wr(4'hA, bd[k], 1'b1);
      cmd(2'h2, ba[k]);
      e = burned(ba[k], bd[k]);
      img[ba[k]] = e;
      cmd(2'h3, ba[k]);
      pt(ba[k]);
      chk(dataReadOut, e);
      chk({6'h0, factoryLock, userLock}, {6'h0, img[2][7], img[3][7]});
    end
    conclude();
  end
endmodule
bind fmc_fuse_controller fmc_checker checker_i (.clk, .rst_n, .testEnable, .regAddr, .regWrStb, .regWrData,
  .cmdReadOut, .defaultsWrStb, .boostRate, .factoryLock, .userLock, .busy);
`default_nettype wire
